//--- logic/ext_area_regs.svh
// register offsets, field positions and reset values of the area block
`ifndef EXT_AREA_REGS_SVH
`define EXT_AREA_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_MUX      8'h00
`define OFS_BSRAM    8'h04
`define OFS_SYSCTL   8'h08
`define OFS_WIDTH    8'h0C
`define OFS_STATUS   8'h10

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define AREA_HI      7
`define AREA_LO      3
`define SYS_RAM_BIT  0
`define SYS_EXT_BIT  1
`define SYS_LE_BIT   2
`define STAT_BUSY    0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_MUX      5'h00
`define RST_BSRAM    5'h00
`define RST_SYS      3'h3
`define RST_WIDTH    5'h00

`endif

//--- logic/ext_area_pkg.sv
// types shared by the external area select and byte align block
package ext_area_pkg;

   // interface type, encoded as {mux select, byte control select}
   typedef enum logic [1:0] {
      IF_BASIC = 2'b00,
      IF_BSRAM = 2'b01,
      IF_MUX   = 2'b10,
      IF_BAD   = 2'b11
   } if_type_t;

   // access size from an internal bus master
   typedef enum logic [1:0] {
      SZ_BYTE = 2'b00,
      SZ_WORD = 2'b01,
      SZ_LONG = 2'b10
   } size_t;

   // sequencer states
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_SETUP = 2'b01,
      ST_WAIT  = 2'b10,
      ST_RESP  = 2'b11
   } st_t;

endpackage : ext_area_pkg

//--- logic/ext_area_select_and_byte_align.sv
// area select, chip select and byte alignment for areas 3 to 7
//
// Notes on behaviour
// - area 3 picks basic 00, byte sram 01, mux i/o 10, 11 prohibited.
// - areas 4 to 7 use the same encoding from their own two bits.
// - an external access to area n drives that area's chip select.
// - in extended mode all of areas 3 and 4 are external.
// - area 5 ram addresses stay internal while ram enable is 1.
// - in extended mode area 5 is external apart from enabled ram and prohibited space.
// - in extended mode areas 6 and 7 are external apart from the i/o register region.
// - lanes follow area width, access size and endian format.
// - an 8-bit area uses only the lower lane, one byte per cycle.
// - 8-bit area: byte 1 cycle, word 2 cycles, longword 4 cycles.
// - big endian sends the most significant byte first.
// - little endian sends the least significant byte first.
// - byte, word and longword requests are turned into bus cycles.
// - a 16-bit area uses both lanes, a byte or a word per cycle.
`timescale 1ns/1ps
`include "ext_area_regs.svh"

module ext_area_select_and_byte_align #(
   parameter int          AW     = 24,
   parameter logic [23:0] RAM_LO = 24'hBF_8000,
   parameter logic [23:0] RAM_HI = 24'hBF_FFFF,
   parameter logic [23:0] BAD_LO = 24'hBE_0000,
   parameter logic [23:0] BAD_HI = 24'hBE_FFFF,
   parameter logic [23:0] IO6_LO = 24'hDF_F000,
   parameter logic [23:0] IO6_HI = 24'hDF_FFFF,
   parameter logic [23:0] IO7_LO = 24'hFF_F000,
   parameter logic [23:0] IO7_HI = 24'hFF_FFFF
) (
   // clock, reset, enable
   input  wire logic                  sys_clk,
   input  wire logic                  reset,
   input  wire logic                  ce,
   // apb register port
   input  wire logic [7:0]            paddr,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   // internal bus master request
   input  wire logic                  req_valid,
   output logic                       req_ready,
   input  wire logic [AW-1:0]         req_addr,
   input  wire ext_area_pkg::size_t   req_size,
   input  wire logic                  req_write,
   input  wire logic [31:0]           req_wdata,
   output logic                       resp_valid,
   output logic                       resp_ext,
   output logic                       resp_err,
   output logic      [31:0]           resp_rdata,
   // external bus cycle, to and from the strobe timing logic
   output logic                       ext_valid,
   input  wire logic                  ext_done,
   output logic      [AW-1:0]         ext_addr,
   output logic                       ext_write,
   output ext_area_pkg::if_type_t     ext_if,
   output logic                       ext_wide,
   output logic                       ext_upper_en,
   output logic                       ext_lower_en,
   output logic      [15:0]           ext_wdata,
   input  wire logic [15:0]           ext_rdata,
   output logic      [7:3]            area_chip_select_n
);
   import ext_area_pkg::*;

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------

   // byte position in the 32-bit word of the k-th byte in memory order
   function automatic logic [1:0] byte_pos(input logic [2:0] k,
                                           input logic [2:0] n,
                                           input logic       le);
      logic [2:0] b;
      b = le ? k : 3'(n - 3'd1 - k);
      return b[1:0];
   endfunction : byte_pos

   // interface type from the two select bits of an area
   function automatic if_type_t if_sel(input logic mux, input logic bc);
      return if_type_t'({mux, bc});
   endfunction : if_sel

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [7:3] mux_interface_control_reg_r;
   logic [7:3] byte_sram_control_reg_r;
   logic [2:0] system_control_reg_r;
   logic [7:3] width_r;
   logic [7:3] prohibited_r;
   logic [31:0] prdata_r;

   // sequencer state
   st_t        st_r;
   st_t        st_nxt;
   logic [AW-1:0] addr_r;
   logic [2:0] n_r;
   logic [2:0] k_r;
   logic [31:0] wdata_r;
   logic [31:0] rdata_r;
   logic       write_r;
   logic [2:0] area_r;
   logic       le_r;
   logic       wide_r;
   logic       resp_ext_r;
   logic       resp_err_r;
   if_type_t   if_r;
   logic       wcyc_r;
   logic       up_r;
   logic [1:0] p0_r;
   logic [1:0] p1_r;
   logic [AW-1:0] ext_addr_r;
   logic [15:0] ext_wdata_r;
   logic [7:3] cs_n_r;

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   wire apb_wr   = ce & psel & penable & pwrite;
   wire apb_rd0  = ce & psel & ~penable;
   wire hit_mux  = paddr == `OFS_MUX;
   wire hit_bsr  = paddr == `OFS_BSRAM;
   wire hit_sys  = paddr == `OFS_SYSCTL;
   wire hit_wid  = paddr == `OFS_WIDTH;
   wire hit_sta  = paddr == `OFS_STATUS;
   wire hit_any  = hit_mux | hit_bsr | hit_sys | hit_wid | hit_sta;
   wire [7:3] bad_clr = (apb_wr & hit_sta) ?
                        pwdata[`AREA_HI:`AREA_LO] : 5'h00;
   wire busy     = st_r != ST_IDLE;

   // read data selection
   wire [31:0] rd_mux =
      hit_mux ? {24'h00_0000, mux_interface_control_reg_r, 3'h0} :
      hit_bsr ? {24'h00_0000, byte_sram_control_reg_r, 3'h0} :
      hit_sys ? {29'h0000_0000, system_control_reg_r} :
      hit_wid ? {24'h00_0000, width_r, 3'h0} :
      hit_sta ? {24'h00_0000, prohibited_r, 2'h0, busy} :
      32'h0000_0000;

   // zero-wait slave, unmapped offsets answer with an error
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~hit_any;
   assign prdata  = prdata_r;

   // control registers
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         mux_interface_control_reg_r <= `RST_MUX;
         byte_sram_control_reg_r     <= `RST_BSRAM;
         system_control_reg_r        <= `RST_SYS;
         width_r                     <= `RST_WIDTH;
         prdata_r                    <= 32'h0000_0000;
      end else if (ce) begin
         if (apb_wr & hit_mux)
            mux_interface_control_reg_r <= pwdata[`AREA_HI:`AREA_LO];
         if (apb_wr & hit_bsr)
            byte_sram_control_reg_r <= pwdata[`AREA_HI:`AREA_LO];
         if (apb_wr & hit_sys)
            system_control_reg_r <= pwdata[2:0];
         if (apb_wr & hit_wid)
            width_r <= pwdata[`AREA_HI:`AREA_LO];
         if (apb_rd0)
            prdata_r <= rd_mux;
      end
   end

   // ----------------------------------------------------------------
   // area decode of the incoming request
   // ----------------------------------------------------------------
   wire [7:0] area_mux_select_bit = {mux_interface_control_reg_r, 3'h0};
   wire [7:0] area_byte_ctrl_select_bit = {byte_sram_control_reg_r, 3'h0};
   wire [7:0] area_wide = {width_r, 3'h0};
   wire internal_ram_enable_bit = system_control_reg_r[`SYS_RAM_BIT];
   wire ext_mode = system_control_reg_r[`SYS_EXT_BIT];
   wire [2:0] area_w = req_addr[AW-1 -: 3];
   wire in_ram = req_addr >= RAM_LO && req_addr <= RAM_HI;
   wire in_bad = req_addr >= BAD_LO && req_addr <= BAD_HI;
   wire in_io  = (req_addr >= IO6_LO && req_addr <= IO6_HI) ||
                 (req_addr >= IO7_LO && req_addr <= IO7_HI);
   wire a34 = area_w == 3'd3 || area_w == 3'd4;
   wire a5  = area_w == 3'd5;
   wire a67 = area_w == 3'd6 || area_w == 3'd7;

   // external space map per area
   wire go_ext = ext_mode & (a34 |
                 (a5 & ~(internal_ram_enable_bit & in_ram)
                  & ~in_bad) |
                 (a67 & ~in_io));

   // interface type of the addressed area
   wire if_type_t req_if = if_sel(area_mux_select_bit[area_w],
                          area_byte_ctrl_select_bit[area_w]);
   wire bad_if = req_if == IF_BAD;

   // byte count of the request
   wire [2:0] req_n = (req_size == SZ_LONG) ? 3'd4 :
                      (req_size == SZ_WORD) ? 3'd2 : 3'd1;

   assign req_ready = ce & (st_r == ST_IDLE);
   wire accept  = req_valid & req_ready;
   wire acc_ext = accept & go_ext & ~bad_if;

   // ----------------------------------------------------------------
   // per-cycle alignment
   // ----------------------------------------------------------------
   wire [AW-1:0] cur_a = addr_r + AW'(k_r);
   wire [2:0] rem  = 3'(n_r - k_r);
   wire wcyc = wide_r & ~cur_a[0] & (rem >= 3'd2);
   wire upper = wide_r & (cur_a[0] ^ ~le_r);
   wire [1:0] p0 = byte_pos(k_r, n_r, le_r);
   wire [1:0] p1 = byte_pos(3'(k_r + 3'd1), n_r, le_r);
   wire [7:0] b0 = wdata_r[8*p0 +: 8];
   wire [7:0] b1 = wdata_r[8*p1 +: 8];
   // the even-address byte sits on the upper lane in big endian
   wire [15:0] dout = wcyc ? (le_r ? {b1, b0} : {b0, b1}) :
                      upper ? {b0, 8'h00} : {8'h00, b0};

   // read bytes back from the lanes used by the cycle
   wire [7:0] r0 = wcyc_r ? (le_r ? ext_rdata[7:0] : ext_rdata[15:8]) :
                   up_r ? ext_rdata[15:8] : ext_rdata[7:0];
   wire [7:0] r1 = le_r ? ext_rdata[15:8] : ext_rdata[7:0];
   wire [2:0] k_nxt = 3'(k_r + (wcyc_r ? 3'd2 : 3'd1));
   wire cyc_end = (st_r == ST_WAIT) & ext_done;
   wire last = k_nxt >= n_r;

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         ST_IDLE:  if (accept) st_nxt = acc_ext ? ST_SETUP : ST_RESP;
         ST_SETUP: st_nxt = ST_WAIT;
         ST_WAIT:  if (ext_done) st_nxt = last ? ST_RESP : ST_SETUP;
         ST_RESP:  st_nxt = ST_IDLE;
         default:  st_nxt = ST_IDLE;
      endcase
   end

   // state and request capture
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         st_r       <= ST_IDLE;
         addr_r     <= '0;
         n_r        <= 3'd1;
         wdata_r    <= 32'h0000_0000;
         write_r    <= 1'b0;
         area_r     <= 3'd3;
         le_r       <= 1'b0;
         wide_r     <= 1'b0;
         if_r       <= IF_BASIC;
         resp_ext_r <= 1'b0;
         resp_err_r <= 1'b0;
      end else if (ce) begin
         st_r <= st_nxt;
         if (accept) begin
            addr_r     <= req_addr;
            n_r        <= req_n;
            wdata_r    <= req_wdata;
            write_r    <= req_write;
            area_r     <= area_w;
            le_r       <= system_control_reg_r[`SYS_LE_BIT];
            wide_r     <= area_wide[area_w];
            if_r       <= req_if;
            resp_ext_r <= acc_ext;
            resp_err_r <= go_ext & bad_if;
         end
      end
   end

   // byte index and lane choice of the cycle in flight
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         k_r    <= 3'd0;
         wcyc_r <= 1'b0;
         up_r   <= 1'b0;
         p0_r   <= 2'd0;
         p1_r   <= 2'd0;
      end else if (ce) begin
         if (accept)
            k_r <= 3'd0;
         else if (cyc_end)
            k_r <= k_nxt;
         if (st_r == ST_SETUP) begin
            wcyc_r <= wcyc;
            up_r   <= upper;
            p0_r   <= p0;
            p1_r   <= p1;
         end
      end
   end

   // external cycle outputs, loaded once per byte or word cycle
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ext_addr_r  <= '0;
         ext_wdata_r <= 16'h0000;
      end else if (ce && st_r == ST_SETUP) begin
         ext_addr_r  <= cur_a;
         ext_wdata_r <= write_r ? dout : 16'h0000;
      end
   end

   // read data assembly, one byte slot per generate branch
   for (genvar i = 0; i < 4; i++) begin : g_rd
      always_ff @(posedge sys_clk) begin
         if (reset)
            rdata_r[8*i +: 8] <= 8'h00;
         else if (ce && accept)
            rdata_r[8*i +: 8] <= 8'h00;
         else if (ce && cyc_end && !write_r) begin
            if (p0_r == 2'(i))
               rdata_r[8*i +: 8] <= r0;
            else if (wcyc_r && p1_r == 2'(i))
               rdata_r[8*i +: 8] <= r1;
         end
      end
   end

   // chip selects and sticky prohibited-setting flags per area
   for (genvar a = 3; a < 8; a++) begin : g_area
      always_ff @(posedge sys_clk) begin
         if (reset) begin
            cs_n_r[a]       <= 1'b1;
            prohibited_r[a] <= 1'b0;
         end else if (ce) begin
            cs_n_r[a] <= !(st_nxt == ST_WAIT && area_r == 3'(a));
            // a new prohibited hit wins over a clear in the same cycle
            prohibited_r[a] <= (prohibited_r[a] & ~bad_clr[a]) |
                               (accept & go_ext & bad_if &
                                area_w == 3'(a));
         end
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign resp_valid   = st_r == ST_RESP;
   assign resp_ext     = resp_ext_r;
   assign resp_err     = resp_err_r;
   assign resp_rdata   = rdata_r;
   assign ext_valid    = st_r == ST_WAIT;
   assign ext_addr     = ext_addr_r;
   assign ext_write    = write_r;
   assign ext_if       = if_r;
   assign ext_wide     = wide_r;
   assign ext_upper_en = ext_valid & (wcyc_r | up_r);
   assign ext_lower_en = ext_valid & (wcyc_r | ~up_r);
   assign ext_wdata    = ext_wdata_r;
   assign area_chip_select_n = cs_n_r;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   // bus cycles completed in the current request
   logic [2:0] cnt_r;
   always_ff @(posedge sys_clk) begin
      if (reset)
         cnt_r <= 3'd0;
      else if (ce && accept)
         cnt_r <= 3'd0;
      else if (ce && cyc_end)
         cnt_r <= 3'(cnt_r + 3'd1);
   end

   AST_IF_ENC: assert property (acc_ext |=>
      if_r == $past(req_if) && if_r != IF_BAD)
      else $error("interface type not taken from area bits");
   AST_BAD_IF: assert property (accept & go_ext & bad_if |=>
      st_r == ST_RESP && resp_err_r && !resp_ext_r)
      else $error("prohibited setting started a cycle");
   AST_CS: assert property (ext_valid |->
      area_chip_select_n == ~(5'h01 << (area_r - 3'd3)))
      else $error("wrong chip select during cycle");
   AST_MAP34: assert property (accept & ext_mode & a34 & ~bad_if
      |=> st_r == ST_SETUP ##1 ext_valid)
      else $error("area 3 or 4 access not external");
   AST_RAM: assert property (accept & a5 & in_ram &
      internal_ram_enable_bit |=> st_r == ST_RESP && !resp_ext_r)
      else $error("enabled ram access went external");
   AST_AREA5: assert property (accept & ext_mode & a5 & ~bad_if &
      ~in_bad & ~(in_ram & internal_ram_enable_bit) |=> resp_ext_r)
      else $error("area 5 external space not external");
   AST_IO: assert property (accept & a67 & in_io |=>
      st_r == ST_RESP && !resp_ext_r)
      else $error("i/o register access went external");
   AST_LOWER: assert property (ext_valid & ~ext_wide |->
      ext_lower_en && !ext_upper_en)
      else $error("8-bit area used the upper lane");
   AST_COUNT: assert property (resp_valid & resp_ext & ~wide_r |->
      cnt_r == n_r)
      else $error("wrong byte cycle count for 8-bit area");
   AST_BE_FIRST: assert property (ext_valid & write_r & ~wide_r &
      ~le_r & k_r == 3'd0 |->
      ext_wdata[7:0] == wdata_r[8*(n_r-3'd1) +: 8])
      else $error("big endian did not send msb first");
   AST_LE_FIRST: assert property (ext_valid & write_r & ~wide_r &
      le_r & k_r == 3'd0 |-> ext_wdata[7:0] == wdata_r[7:0])
      else $error("little endian did not send lsb first");
   AST_WIDE: assert property (ext_valid & wcyc_r |->
      ext_wide && ext_upper_en && ext_lower_en)
      else $error("word cycle without both lanes");

   COV_LONG8: cover property (resp_valid & resp_ext & ~wide_r &
      n_r == 3'd4);
   COV_ODD16: cover property (ext_valid & ext_wide & ~wcyc_r & k_r != 0);
   COV_RAM: cover property (accept & a5 & in_ram & internal_ram_enable_bit);
   COV_BAD: cover property (resp_valid & resp_err);

endmodule : ext_area_select_and_byte_align

//--- tb/ext_dev_model.sv
// behavioural external device answering byte and word bus cycles
`timescale 1ns/1ps
module ext_dev_model (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        reset,
   // bus cycle from the block
   input  wire logic        ext_valid,
   output logic             ext_done,
   input  wire logic [23:0] ext_addr,
   input  wire logic        ext_write,
   input  wire logic [1:0]  ext_if,
   input  wire logic        ext_upper_en,
   input  wire logic        ext_lower_en,
   input  wire logic [15:0] ext_wdata,
   output logic      [15:0] ext_rdata,
   input  wire logic [7:3]  cs_n
);
   logic [7:0]  mem [256];
   logic [15:0] junk_r;
   logic [15:0] last_wd;
   logic [1:0]  last_if;
   logic [1:0]  last_lanes;
   logic [7:3]  last_cs;
   int          dly = 0;
   int          wait_r;
   int          n_cyc;

   // storage starts cleared
   initial begin
      foreach (mem[i]) mem[i] = 8'h00;
   end

   // lane data only inside a cycle, a changing pattern outside it
   assign ext_rdata = ext_valid ? {~mem[ext_addr[7:0]], mem[ext_addr[7:0]]}
                                : junk_r;

   // end each cycle after dly wait cycles, logging what the block drove
   always @(posedge sys_clk) begin
      junk_r <= ~junk_r;
      if (reset) begin
         junk_r   <= 16'hA5C3;
         ext_done <= 1'b0;
         wait_r   <= 0;
         n_cyc    <= 0;
      end else if (ext_done) begin
         ext_done <= 1'b0;
         wait_r   <= 0;
      end else if (ext_valid && wait_r >= dly) begin
         ext_done   <= 1'b1;
         n_cyc      <= n_cyc + 1;
         last_wd    <= ext_wdata;
         last_if    <= ext_if;
         last_lanes <= {ext_upper_en, ext_lower_en};
         last_cs    <= cs_n;
         if (ext_write) mem[ext_addr[7:0]] <= ext_wdata[7:0];
      end else if (ext_valid) begin
         wait_r <= wait_r + 1;
      end
   end
endmodule : ext_dev_model

//--- tb/ext_area_select_and_byte_align_tb.sv
// self-checking bench for the area select and byte align block
`timescale 1ns/1ps
module ext_area_select_and_byte_align_tb;
   import ext_area_pkg::*;
   logic        sys_clk, reset, ce, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, req_wdata, resp_rdata, rd;
   logic        req_valid, req_ready, req_write, resp_valid, resp_ext;
   logic        resp_err, ext_valid, ext_done, ext_write, ext_wide;
   logic        up_en, lo_en, er, rx, rerr;
   logic [23:0] req_addr, ext_addr;
   size_t       req_size;
   if_type_t    ext_if;
   logic [15:0] ext_wdata, ext_rdata;
   logic [7:3]  cs_n;
   logic [4:0]  cs_e;
   int          error_cnt, n_compared, c0;
   int          areas [3] = '{3, 5, 7};
   logic [23:0] bases [3] = '{24'h60_0008, 24'hA0_0008, 24'hE0_0008};
   logic [31:0] rst_exp [5] = '{32'h0, 32'h0, 32'h3, 32'h0, 32'h0};
   // {sysctl, address, external}
   logic [31:0] maps [10] = '{32'h7BF8_0000, 32'h6BF8_0001, 32'h6BE0_1000,
      32'h6A00_1001, 32'h6DFF_0100, 32'h6DF0_0101, 32'h6FFF_0000,
      32'h4600_0000, 32'h6600_0001, 32'h6200_0000};

   ext_area_select_and_byte_align i_ext_area_select_and_byte_align (
      .sys_clk(sys_clk), .reset(reset), .ce(ce), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .req_valid(req_valid),
      .req_ready(req_ready), .req_addr(req_addr), .req_size(req_size),
      .req_write(req_write), .req_wdata(req_wdata), .resp_valid(resp_valid),
      .resp_ext(resp_ext), .resp_err(resp_err), .resp_rdata(resp_rdata),
      .ext_valid(ext_valid), .ext_done(ext_done), .ext_addr(ext_addr),
      .ext_write(ext_write), .ext_if(ext_if), .ext_wide(ext_wide),
      .ext_upper_en(up_en), .ext_lower_en(lo_en), .ext_wdata(ext_wdata),
      .ext_rdata(ext_rdata), .area_chip_select_n(cs_n));
   ext_dev_model i_ext_dev_model (
      .sys_clk(sys_clk), .reset(reset), .ext_valid(ext_valid),
      .ext_done(ext_done), .ext_addr(ext_addr), .ext_write(ext_write),
      .ext_if(ext_if), .ext_upper_en(up_en), .ext_lower_en(lo_en),
      .ext_wdata(ext_wdata), .ext_rdata(ext_rdata), .cs_n(cs_n));

   // 25 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   // ----------------------------------------------------------------
   // access tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // one apb transfer, answer kept in rd and er
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      // answer taken at the edge where pready is seen high
      do @(posedge sys_clk); while (pready !== 1'b1 && ++n < 20);
      chk("pready", 32'h1, pready);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask : apb

   // one master request; nc is the number of bus cycles it must cost
   task automatic req(input logic [23:0] a, input size_t s, input logic w,
                      input logic [31:0] d, input int nc);
      int n;
      n = 0;
      c0 = i_ext_dev_model.n_cyc;
      req_valid <= 1'b1;
      req_addr  <= a;
      req_size  <= s;
      req_write <= w;
      req_wdata <= d;
      // request held until the edge where req_ready is seen high
      do @(posedge sys_clk); while (req_ready !== 1'b1 && ++n < 50);
      req_valid <= 1'b0;
      n = 0;
      do @(posedge sys_clk); while (resp_valid !== 1'b1 && ++n < 300);
      chk("resp_valid", 32'h1, resp_valid);
      rx   = resp_ext;
      rerr = resp_err;
      rd   = resp_rdata;
      chk("bus cycles", nc, i_ext_dev_model.n_cyc - c0);
      @(posedge sys_clk);
   endtask : req

   task automatic end_sim();
      $display("comparisons %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_sim

   // ----------------------------------------------------------------
   // test sequence
   // ----------------------------------------------------------------
   initial begin
      {error_cnt, n_compared} = 0;
      {ce, reset} = 2'b11;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {req_valid, req_write, req_addr, req_wdata} = '0;
      req_size = SZ_BYTE;
      repeat (12) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      foreach (rst_exp[i]) begin
         apb(1'b0, 8'(i * 4), 32'h0);
         chk("reg reset", rst_exp[i], rd);
      end
      apb(1'b0, 8'h14, 32'h0);
      chk("unmapped err", 32'h1, er);
      // byte alignment in an 8-bit area, big endian
      req(24'h60_0010, SZ_LONG, 1'b1, 32'h1122_3344, 4);
      for (int k = 0; k < 4; k++)
         chk("be byte", 8'h11 * (k + 1), i_ext_dev_model.mem[16 + k]);
      chk("lower lane", 32'h1, i_ext_dev_model.last_lanes);
      chk("cs area 3", 32'h1E, i_ext_dev_model.last_cs);
      chk("external", 32'h1, rx);
      req(24'h60_0030, SZ_WORD, 1'b1, 32'h0000_AABB, 2);
      chk("be word", 32'hAABB, {i_ext_dev_model.mem[48],
                                i_ext_dev_model.mem[49]});
      i_ext_dev_model.dly = 3;
      req(24'h60_0010, SZ_LONG, 1'b0, 32'h0, 4);
      chk("be read", 32'h1122_3344, rd);
      i_ext_dev_model.dly = 0;
      req(24'h60_0012, SZ_BYTE, 1'b0, 32'h0, 1);
      chk("byte read", 32'h33, rd);
      // little endian
      apb(1'b1, 8'h08, 32'h7);
      req(24'h80_0020, SZ_LONG, 1'b1, 32'h5566_7788, 4);
      for (int k = 0; k < 4; k++)
         chk("le byte", 8'h88 - 8'h11 * k, i_ext_dev_model.mem[32 + k]);
      req(24'h60_0010, SZ_LONG, 1'b0, 32'h0, 4);
      chk("le read", 32'h4433_2211, rd);
      req(24'h60_0030, SZ_WORD, 1'b0, 32'h0, 2);
      chk("le word", 32'hBBAA, rd);
      // interface codes per area
      foreach (areas[j]) for (int i = 0; i < 4; i++) begin
         apb(1'b1, 8'h00, 32'(i / 2) << areas[j]);
         apb(1'b1, 8'h04, 32'(i % 2) << areas[j]);
         req(bases[j], SZ_BYTE, 1'b0, 32'h0, (i == 3) ? 0 : 1);
         chk("prohibited", i == 3, rerr);
         cs_e = ~(5'h01 << (areas[j] - 3));
         if (i < 3) chk("if type", i, i_ext_dev_model.last_if);
         if (i < 3) chk("chip select", cs_e, i_ext_dev_model.last_cs);
      end
      apb(1'b0, 8'h10, 32'h0);
      chk("sticky flags", 32'hA8, rd);
      apb(1'b1, 8'h10, 32'hA8);
      apb(1'b0, 8'h10, 32'h0);
      chk("flags cleared", 32'h0, rd);
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b1, 8'h04, 32'h0);
      // address mapping per area and mode
      foreach (maps[k]) begin
         apb(1'b1, 8'h08, {28'h0, maps[k][31:28]});
         req(maps[k][27:4], SZ_BYTE, 1'b0, 32'h0, maps[k][0]);
         chk("mapped", maps[k][0], rx);
      end
      // 16-bit area 3, big endian
      apb(1'b1, 8'h08, 32'h3);
      apb(1'b1, 8'h0C, 32'h08);
      req(24'h60_0040, SZ_WORD, 1'b1, 32'h0000_CCDD, 1);
      chk("wide lanes", 32'h3, i_ext_dev_model.last_lanes);
      chk("wide data", 32'hCCDD, i_ext_dev_model.last_wd);
      req(24'h60_0041, SZ_BYTE, 1'b1, 32'h0000_0055, 1);
      chk("odd lane", 32'h1, i_ext_dev_model.last_lanes);
      req(24'h60_0042, SZ_BYTE, 1'b1, 32'h0000_0066, 1);
      chk("even lane", 32'h2, i_ext_dev_model.last_lanes);
      req(24'h60_0040, SZ_WORD, 1'b0, 32'h0, 1);
      chk("wide read", 32'h22DD, rd);
      end_sim();
   end

   // watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge sys_clk);
      error_cnt++;
      end_sim();
   end
endmodule : ext_area_select_and_byte_align_tb
